//--- logic/pbcs_pkg.sv
// constants shared by the control/status register block
// assumes: a core clock domain and a management link clock domain
package pbcs_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int CTL_RESET = 15;
  localparam int CTL_LOOP = 14;
  localparam int CTL_SPEED = 13;
  localparam int CTL_ANEN = 12;
  localparam int CTL_PDOWN = 11;
  localparam int CTL_ISO = 10;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COLTEST = 7;
  localparam int CTL_TXDIS = 0;
  localparam logic [15:0] CTL_WR_MASK = 16'hff81; // writable bits only
  localparam logic [15:0] CTL_SC_MASK = 16'h8200; // self-clearing bits
  // ------------------------------------------------------------
  // status field positions and fixed values
  // ------------------------------------------------------------
  localparam int ST_AN_DONE = 5;
  localparam int ST_RFAULT = 4;
  localparam int ST_LINK = 2;
  localparam int ST_JABBER = 1;
  localparam logic [15:0] STAT_ABILITY = 16'h7800;
  localparam logic [15:0] STAT_NOPRE = 16'h0040;
  localparam logic [15:0] STAT_ANABLE = 16'h0008;
  localparam logic [15:0] STAT_EXT = 16'h0001;
  // ------------------------------------------------------------
  // management frame
  // ------------------------------------------------------------
  localparam logic [4:0] MGMT_PHY_ADDR = 5'h01;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [4:0] HDR_LAST = 5'h0c;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  typedef enum logic [4:0] {
    FR_IDLE = 5'b00001,
    FR_HDR = 5'b00010,
    FR_TA = 5'b00100,
    FR_RDAT = 5'b01000,
    FR_WDAT = 5'b10000
  } pbcs_frame_e;
endpackage

//--- logic/pbcs_if.sv
// signals crossing between the register core and the serial engine
// assumes: every bus is held stable while its toggle is unanswered
`timescale 1ns/10ps
interface pbcs_if;
  logic snap_req; // core toggles when a new snapshot is offered
  logic snap_ack; // engine echoes the toggle once copied
  logic [15:0] snap_ctrl; // control word snapshot
  logic [15:0] snap_stat; // status word snapshot
  logic wr_tgl; // engine toggles per register write
  logic [4:0] wr_addr; // written register offset
  logic [15:0] wr_data; // written value
  logic rd_tgl; // engine toggles per status read
  modport core(output snap_req, snap_ctrl, snap_stat,
               input snap_ack, wr_tgl, wr_addr, wr_data, rd_tgl);
  modport mgmt(input snap_req, snap_ctrl, snap_stat,
               output snap_ack, wr_tgl, wr_addr, wr_data, rd_tgl);
endinterface

//--- logic/pbcs_mgmt.sv
// serial management frame engine on the link clock
// assumes: frames are sampled and driven on the rising link clock edge
`timescale 1ns/10ps
module pbcs_mgmt
  import pbcs_pkg::*;
(
  // link clock and raw reset
  input wire logic mgmt_clk_i,
  input wire logic rst_n_i,
  // serial data pin
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // crossing to the register core
  pbcs_if.mgmt xfer
);
  // ------------------------------------------------------------
  // reset and snapshot crossing
  // ------------------------------------------------------------
  logic rst_s1_reg, rst_s2_reg; // reset synchroniser
  logic req_s1_reg, req_s2_reg; // snapshot request synchroniser
  logic ack_reg; // snapshot echo
  logic [15:0] ctrl_copy_reg, stat_copy_reg; // local snapshot copy
  // bring reset into this domain
  always_ff @(posedge mgmt_clk_i) begin
    rst_s1_reg <= rst_n_i;
    rst_s2_reg <= rst_s1_reg;
  end
  // copy a stable snapshot and echo its toggle on the same edge
  always_ff @(posedge mgmt_clk_i) begin
    req_s1_reg <= xfer.snap_req;
    req_s2_reg <= req_s1_reg;
    if (!rst_s2_reg) begin
      ack_reg <= 1'b0;
      ctrl_copy_reg <= 16'h0000;
      stat_copy_reg <= 16'h0000;
    end else if (req_s2_reg != ack_reg) begin
      ctrl_copy_reg <= xfer.snap_ctrl;
      stat_copy_reg <= xfer.snap_stat;
      ack_reg <= req_s2_reg;
    end
  end
  // ------------------------------------------------------------
  // frame decoder
  // ------------------------------------------------------------
  pbcs_frame_e state_reg; // frame phase
  logic [4:0] cnt_reg; // bit counter inside a phase
  logic [15:0] sh_reg; // shift register
  logic pre_reg; // previous idle bit was high
  logic rd_op_reg; // current frame is a read
  logic [4:0] addr_reg; // current register offset
  logic wr_tgl_reg, rd_tgl_reg; // event toggles
  logic [4:0] wr_addr_reg; // held write offset
  logic [15:0] wr_data_reg; // held write value
  wire [12:0] hdr = {sh_reg[11:0], mdio_i}; // start tail, op, phy, reg
  wire hdr_ok = hdr[12] && (hdr[11:10] == OP_RD || hdr[11:10] == OP_WR) && hdr[9:5] == MGMT_PHY_ADDR;
  wire [15:0] rdata = (addr_reg == REG_CTRL) ? ctrl_copy_reg :
                      (addr_reg == REG_STAT) ? stat_copy_reg : 16'h0000;
  wire [4:0] cnt_inc = 5'(cnt_reg + 5'h01);
  // preamble is optional: one high bit then a low start bit opens a frame
  always_ff @(posedge mgmt_clk_i) begin
    if (!rst_s2_reg) begin
      state_reg <= FR_IDLE;
      cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
      pre_reg <= 1'b0;
      rd_op_reg <= 1'b0;
      addr_reg <= 5'h00;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      wr_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        FR_IDLE: begin
          pre_reg <= mdio_i;
          cnt_reg <= 5'h00;
          if (pre_reg && !mdio_i) begin
            state_reg <= FR_HDR;
          end
        end
        FR_HDR: begin
          sh_reg <= {sh_reg[14:0], mdio_i};
          cnt_reg <= cnt_inc;
          if (cnt_reg == HDR_LAST) begin
            cnt_reg <= 5'h00;
            pre_reg <= 1'b0;
            rd_op_reg <= (hdr[11:10] == OP_RD);
            addr_reg <= hdr[4:0];
            state_reg <= hdr_ok ? FR_TA : FR_IDLE;
          end
        end
        FR_TA: begin
          cnt_reg <= cnt_inc;
          mdio_oe_o <= rd_op_reg; // drive low in the second turnaround bit
          mdio_o <= 1'b0;
          if (cnt_reg == TA_LAST) begin
            cnt_reg <= 5'h00;
            if (rd_op_reg) begin
              sh_reg <= rdata;
              mdio_o <= rdata[15];
              state_reg <= FR_RDAT;
              if (addr_reg == REG_STAT) begin
                rd_tgl_reg <= ~rd_tgl_reg;
              end
            end else begin
              state_reg <= FR_WDAT;
            end
          end
        end
        FR_RDAT: begin
          cnt_reg <= cnt_inc;
          mdio_o <= sh_reg[14];
          sh_reg <= {sh_reg[14:0], 1'b0};
          if (cnt_reg == DATA_LAST) begin
            mdio_oe_o <= 1'b0;
            mdio_o <= 1'b0;
            state_reg <= FR_IDLE;
          end
        end
        FR_WDAT: begin
          cnt_reg <= cnt_inc;
          sh_reg <= {sh_reg[14:0], mdio_i};
          if (cnt_reg == DATA_LAST) begin
            wr_data_reg <= {sh_reg[14:0], mdio_i};
            wr_addr_reg <= addr_reg;
            wr_tgl_reg <= ~wr_tgl_reg;
            state_reg <= FR_IDLE;
          end
        end
      endcase
    end
  end
  // hand events and held data to the core
  assign xfer.snap_ack = ack_reg;
  assign xfer.wr_tgl = wr_tgl_reg;
  assign xfer.wr_addr = wr_addr_reg;
  assign xfer.wr_data = wr_data_reg;
  assign xfer.rd_tgl = rd_tgl_reg;
endmodule

//--- logic/pbcs_regs.sv
// basic control and basic status registers of a 10/100 transceiver
// assumes: datapath status inputs are on CLOCK_I, straps and link are not
`timescale 1ns/10ps
module pbcs_regs
  import pbcs_pkg::*;
(
  // core clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // management link
  input wire logic MGMT_CLK_I,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_O,
  // strapping pins
  input wire logic SPEED_STRAP_I,
  input wire logic NEGOTIATION_ENABLE_STRAP_PIN_I,
  input wire logic ISOLATE_STRAP_I,
  input wire logic DUPLEX_STRAP_I,
  // datapath status
  input wire logic AN_DONE_I,
  input wire logic AN_SPEED_100_I,
  input wire logic AN_FULL_DUPLEX_I,
  input wire logic LINK_UP_I,
  input wire logic REMOTE_FAULT_I,
  input wire logic JABBER_I,
  // datapath control
  output logic SOFT_RESET_O,
  output logic LOOPBACK_O,
  output logic SPEED_100_O,
  output logic FULL_DUPLEX_O,
  output logic AN_ENABLE_O,
  output logic AN_RESTART_O,
  output logic POWER_DOWN_O,
  output logic ISOLATE_O,
  output logic COL_TEST_O,
  output logic TX_DISABLE_O
);
  // ------------------------------------------------------------
  // serial engine on the link clock
  // ------------------------------------------------------------
  pbcs_if xfer ();
  pbcs_mgmt u_mgmt (
    .mgmt_clk_i(MGMT_CLK_I),
    .rst_n_i(RST_N_I),
    .mdio_i(MDIO_I),
    .mdio_o(MDIO_O),
    .mdio_oe_o(MDIO_OE_O),
    .xfer(xfer.mgmt)
  );

  // ------------------------------------------------------------
  // strap synchronisers
  // ------------------------------------------------------------
  logic [3:0] strap_s1_reg; // first stage, read only by second
  logic [3:0] strap_s2_reg; // settled strap levels
  logic link_s1_reg, link_s2_reg; // link level synchroniser, not reset
  // straps are not reset, so reset must be held three edges
  always_ff @(posedge CLOCK_I) begin
    strap_s1_reg <= {SPEED_STRAP_I, NEGOTIATION_ENABLE_STRAP_PIN_I, ISOLATE_STRAP_I, DUPLEX_STRAP_I};
    strap_s2_reg <= strap_s1_reg;
    link_s1_reg <= LINK_UP_I;
    link_s2_reg <= link_s1_reg;
  end
  wire strap_speed = strap_s2_reg[3]; // speed default
  wire strap_an = strap_s2_reg[2]; // negotiation default
  wire strap_iso = strap_s2_reg[1]; // isolate default
  wire strap_dup = strap_s2_reg[0]; // duplex strap, inverted on use
  wire link_up = link_s2_reg; // settled link level

  // ------------------------------------------------------------
  // event crossings from the link domain
  // ------------------------------------------------------------
  logic wr_s1_reg, wr_s2_reg, wr_s3_reg; // write toggle sync
  logic rd_s1_reg, rd_s2_reg, rd_s3_reg; // read toggle sync
  logic ack_s1_reg, ack_s2_reg; // snapshot echo sync
  // three stages so the edge detect never looks at stage one
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      wr_s1_reg <= 1'b0;
      wr_s2_reg <= 1'b0;
      wr_s3_reg <= 1'b0;
      rd_s1_reg <= 1'b0;
      rd_s2_reg <= 1'b0;
      rd_s3_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      wr_s1_reg <= xfer.wr_tgl;
      wr_s2_reg <= wr_s1_reg;
      wr_s3_reg <= wr_s2_reg;
      rd_s1_reg <= xfer.rd_tgl;
      rd_s2_reg <= rd_s1_reg;
      rd_s3_reg <= rd_s2_reg;
      ack_s1_reg <= xfer.snap_ack;
      ack_s2_reg <= ack_s1_reg;
    end
  end
  wire wr_ev = wr_s2_reg ^ wr_s3_reg; // one cycle per write
  wire rd_ev = rd_s2_reg ^ rd_s3_reg; // one cycle per status read

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic [15:0] ctrl_reg; // stored control word
  logic [15:0] ctrl_next;
  logic [15:0] ctrl_default; // value after hard or soft reset
  wire soft_rst = ctrl_reg[CTL_RESET]; // soft reset in progress
  wire pd = ctrl_reg[CTL_PDOWN]; // power down
  wire an_en = ctrl_reg[CTL_ANEN]; // negotiation enabled
  wire ctrl_write = wr_ev && (xfer.wr_addr == REG_CTRL); // status writes ignored
  // defaults, partly taken from straps
  always_comb begin
    ctrl_default = 16'h0000;
    ctrl_default[CTL_SPEED] = strap_speed;
    ctrl_default[CTL_ANEN] = strap_an;
    ctrl_default[CTL_ISO] = strap_iso;
    ctrl_default[CTL_DUPLEX] = ~strap_dup;
  end
  // soft reset beats a write landing in the same cycle
  always_comb begin
    if (soft_rst) begin
      ctrl_next = ctrl_default;
    end else if (ctrl_write) begin
      ctrl_next = xfer.wr_data & CTL_WR_MASK;
    end else begin
      ctrl_next = ctrl_reg & ~CTL_SC_MASK;
    end
  end
  // control state, defaults loaded while reset is held
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ctrl_reg <= ctrl_default;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ------------------------------------------------------------
  // status latches
  // ------------------------------------------------------------
  logic rf_reg, jab_reg, link_reg, an_done_reg; // live status bits
  logic [15:0] status_word; // assembled status register
  wire run = !pd && !soft_rst; // datapath is alive
  // set wins over the read clear, power down freezes events
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || soft_rst) begin
      rf_reg <= 1'b0;
      jab_reg <= 1'b0;
      link_reg <= 1'b0;
      an_done_reg <= 1'b0;
    end else begin
      rf_reg <= (REMOTE_FAULT_I && run) || (rf_reg && !rd_ev);
      jab_reg <= (JABBER_I && run) || (jab_reg && !rd_ev);
      link_reg <= link_up && run && (link_reg || rd_ev);
      an_done_reg <= AN_DONE_I && run;
    end
  end
  // fixed abilities plus live bits, reserved bits stay zero
  always_comb begin
    status_word = STAT_ABILITY | STAT_NOPRE | STAT_ANABLE | STAT_EXT;
    status_word[ST_AN_DONE] = an_done_reg;
    status_word[ST_RFAULT] = rf_reg;
    status_word[ST_LINK] = link_reg;
    status_word[ST_JABBER] = jab_reg;
  end

  // ------------------------------------------------------------
  // snapshot publish toward the link domain
  // ------------------------------------------------------------
  logic snap_req_reg; // offer toggle
  logic [15:0] snap_ctrl_reg, snap_stat_reg; // held while unanswered
  // a new snapshot only once the previous one was taken
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      snap_req_reg <= 1'b0;
      snap_ctrl_reg <= 16'h0000;
      snap_stat_reg <= 16'h0000;
    end else if (ack_s2_reg == snap_req_reg) begin
      snap_ctrl_reg <= ctrl_reg;
      snap_stat_reg <= status_word;
      snap_req_reg <= ~snap_req_reg;
    end
  end
  assign xfer.snap_req = snap_req_reg;
  assign xfer.snap_ctrl = snap_ctrl_reg;
  assign xfer.snap_stat = snap_stat_reg;

  // ------------------------------------------------------------
  // datapath steering outputs
  // ------------------------------------------------------------
  logic soft_out_reg, loop_out_reg, speed_out_reg, dup_out_reg;
  logic anen_out_reg, restart_out_reg, pd_out_reg, iso_out_reg;
  logic col_out_reg, txdis_out_reg;
  wire speed_sel = an_en ? AN_SPEED_100_I : ctrl_reg[CTL_SPEED];
  wire dup_sel = an_en ? AN_FULL_DUPLEX_I : ctrl_reg[CTL_DUPLEX];
  // every steering output is registered
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      soft_out_reg <= 1'b0;
      loop_out_reg <= 1'b0;
      speed_out_reg <= 1'b0;
      dup_out_reg <= 1'b0;
      anen_out_reg <= 1'b0;
      restart_out_reg <= 1'b0;
      pd_out_reg <= 1'b0;
      iso_out_reg <= 1'b0;
      col_out_reg <= 1'b0;
      txdis_out_reg <= 1'b0;
    end else begin
      soft_out_reg <= soft_rst;
      loop_out_reg <= ctrl_reg[CTL_LOOP];
      speed_out_reg <= speed_sel;
      dup_out_reg <= dup_sel;
      anen_out_reg <= an_en;
      restart_out_reg <= ctrl_reg[CTL_RESTART] && !pd;
      pd_out_reg <= pd;
      iso_out_reg <= ctrl_reg[CTL_ISO];
      col_out_reg <= ctrl_reg[CTL_COLTEST];
      txdis_out_reg <= ctrl_reg[CTL_TXDIS] || pd;
    end
  end
  assign SOFT_RESET_O = soft_out_reg;
  assign LOOPBACK_O = loop_out_reg;
  assign SPEED_100_O = speed_out_reg;
  assign FULL_DUPLEX_O = dup_out_reg;
  assign AN_ENABLE_O = anen_out_reg;
  assign AN_RESTART_O = restart_out_reg;
  assign POWER_DOWN_O = pd_out_reg;
  assign ISOLATE_O = iso_out_reg;
  assign COL_TEST_O = col_out_reg;
  assign TX_DISABLE_O = txdis_out_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // restart write, then one-cycle bit, then one-cycle pulse
  sequence restart_wr_s;
    ctrl_write && !soft_rst && xfer.wr_data[CTL_RESTART] && !xfer.wr_data[CTL_PDOWN];
  endsequence
  sequence restart_pulse_s;
    ##1 ctrl_reg[CTL_RESTART] ##1 (AN_RESTART_O && !ctrl_reg[CTL_RESTART]) ##1 !AN_RESTART_O;
  endsequence
  restart_pulse_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I) restart_wr_s |-> restart_pulse_s)
    else $error("restart pulse wrong");
  soft_clear_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    soft_rst |=> !soft_rst && ctrl_reg == $past(ctrl_default) && SOFT_RESET_O)
    else $error("soft reset did not clear or reload");
  an_strap_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    soft_rst |=> an_en == $past(strap_an) ##1 AN_ENABLE_O == $past(strap_an, 2))
    else $error("negotiation default not from strap");
  iso_strap_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    soft_rst |=> ##1 ISOLATE_O == $past(strap_iso, 2))
    else $error("isolate default not from strap");
  dup_strap_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    soft_rst |=> ctrl_reg[CTL_DUPLEX] != $past(strap_dup))
    else $error("duplex default not inverted strap");
  speed_manual_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !an_en |=> SPEED_100_O == $past(ctrl_reg[CTL_SPEED]))
    else $error("manual speed not applied");
  an_override_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    an_en |=> SPEED_100_O == $past(AN_SPEED_100_I) && FULL_DUPLEX_O == $past(AN_FULL_DUPLEX_I))
    else $error("negotiated result not applied");
  col_write_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ctrl_write && !soft_rst ##1 !soft_rst |=> COL_TEST_O == $past(xfer.wr_data[CTL_COLTEST], 2))
    else $error("collision test bit not applied");
  tx_off_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ctrl_reg[CTL_TXDIS] |=> TX_DISABLE_O)
    else $error("transmitter not disabled");
  pd_stop_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    pd |=> TX_DISABLE_O && POWER_DOWN_O && !AN_RESTART_O && !status_word[ST_AN_DONE])
    else $error("power down left datapath running");
  fixed_bits_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    $past(RST_N_I) |-> snap_stat_reg[15:6] == 10'h1e1 && snap_stat_reg[3] && snap_stat_reg[0])
    else $error("fixed status bits wrong");
  reserved_zero_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ctrl_write |=> ctrl_reg[6:1] == 6'h00)
    else $error("reserved control bits stored");
  an_done_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !AN_DONE_I |=> !status_word[ST_AN_DONE])
    else $error("negotiation complete without process");
  fault_hold_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (REMOTE_FAULT_I && run || rf_reg && !rd_ev && !soft_rst) |=> rf_reg)
    else $error("remote fault latch lost");
  link_low_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !link_up ##1 !rd_ev [*2] |-> !link_reg)
    else $error("link status not latched low");

  // ------------------------------------------------------------
  // checks on self-clearing bits, steering and latches
  // ------------------------------------------------------------
  restart_clear_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ctrl_reg[CTL_RESTART] && !ctrl_write |=> !ctrl_reg[CTL_RESTART])
    else $error("restart bit did not clear");
  soft_pulse_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    SOFT_RESET_O |=> !SOFT_RESET_O)
    else $error("soft reset pulse too long");
  tx_on_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !ctrl_reg[CTL_TXDIS] && !pd |=> !TX_DISABLE_O)
    else $error("transmitter disabled without cause");
  dup_follow_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !an_en |=> FULL_DUPLEX_O == $past(ctrl_reg[CTL_DUPLEX]))
    else $error("manual duplex not applied");
  ctrl_store_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ctrl_write && !soft_rst |=> ctrl_reg == ($past(xfer.wr_data) & CTL_WR_MASK))
    else $error("control write stored wrongly");
  jab_hold_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (JABBER_I && run || jab_reg && !rd_ev && !soft_rst) |=> jab_reg)
    else $error("jabber latch lost");
  pd_freeze_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    pd && !rf_reg && !jab_reg |=> !rf_reg && !jab_reg && !link_reg)
    else $error("event latched in power down");
  link_read_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    rd_ev && link_up && run |=> link_reg)
    else $error("link status not restored by read");
  an_done_set_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    AN_DONE_I && run |=> status_word[ST_AN_DONE])
    else $error("negotiation complete not shown");
endmodule

//--- dv/pbcs_sm_model.sv
// ------------------------------------------------------------
// station management controller model for the serial data pin
// ------------------------------------------------------------
// assumes: pin has a pull-up, link clock stands still between model tasks
`timescale 1ns/10ps
module pbcs_sm_model
  import pbcs_pkg::*;
(
  // link clock and driven data
  output logic mgmt_clk_o,
  output logic mdio_drv_o,
  // resolved pin level
  input wire logic mdio_i
);
  // idle levels at time zero
  initial begin
    mgmt_clk_o = 1'b0;
    mdio_drv_o = 1'b1;
  end
  // one link bit: data set while clock low, then rise and fall
  task automatic tick();
    #3 mgmt_clk_o = 1'b1;
    #3 mgmt_clk_o = 1'b0;
  endtask
  // idle ones, pin left to the pull-up
  task automatic idle(input int n);
    mdio_drv_o = 1'b1;
    repeat (n) tick();
  endtask
  // shift n bits msb first
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      mdio_drv_o = v[i];
      tick();
    end
  endtask
  // full write frame, then a long idle for the crossing
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    shift(16'({2'h1, OP_WR, MGMT_PHY_ADDR, ra}), 14);
    shift(16'h0002, 2);
    shift(d, 16);
    idle(40);
  endtask
  // read frame: release at turnaround, sample while clock low
  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    shift(16'({2'h1, OP_RD, MGMT_PHY_ADDR, ra}), 14);
    mdio_drv_o = 1'b1;
    tick();
    tick();
    for (int i = 15; i >= 0; i--) begin
      d[i] = mdio_i;
      tick();
    end
    idle(40);
  endtask
endmodule

//--- dv/tb_phy_basic_control_status_regs.sv
// ------------------------------------------------------------
// self-checking bench for the control/status register block
// ------------------------------------------------------------
// assumes: straps set by the bench, datapath status driven on falling core edge
`timescale 1ns/10ps
module tb_phy_basic_control_status_regs
  import pbcs_pkg::*;
;
  // clocks, pin and datapath signals
  logic clk, rst_n, mclk, mdrv, mdo, mdoe, mdio;
  logic an_done, an_spd, an_fd, link, rfault, jab;
  logic sp_st, an_st, iso_st, dup_st; // strap levels
  logic s_rst, loop, spd, fd, an_en, an_rst, pdown, iso, col, txdis;
  // counters
  int n_errors, n_compared, n_cyc, n_srst, n_anrst, k;
  // pin level: block when enabled, else the master or pull-up
  assign mdio = mdoe ? mdo : mdrv;
  pbcs_regs pbcs_regs_inst(.CLOCK_I(clk), .RST_N_I(rst_n), .MGMT_CLK_I(mclk),
    .MDIO_I(mdio), .MDIO_O(mdo), .MDIO_OE_O(mdoe), .SPEED_STRAP_I(sp_st),
    .NEGOTIATION_ENABLE_STRAP_PIN_I(an_st), .ISOLATE_STRAP_I(iso_st), .DUPLEX_STRAP_I(dup_st),
    .AN_DONE_I(an_done), .AN_SPEED_100_I(an_spd), .AN_FULL_DUPLEX_I(an_fd),
    .LINK_UP_I(link), .REMOTE_FAULT_I(rfault), .JABBER_I(jab),
    .SOFT_RESET_O(s_rst), .LOOPBACK_O(loop), .SPEED_100_O(spd), .FULL_DUPLEX_O(fd),
    .AN_ENABLE_O(an_en), .AN_RESTART_O(an_rst), .POWER_DOWN_O(pdown),
    .ISOLATE_O(iso), .COL_TEST_O(col), .TX_DISABLE_O(txdis));
  pbcs_sm_model pbcs_sm_model_inst(.mgmt_clk_o(mclk), .mdio_drv_o(mdrv), .mdio_i(mdio));
  // core clock 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // pulse counters and hang guard
  always @(posedge clk) begin
    n_cyc++;
    if (s_rst === 1'b1) n_srst++;
    if (an_rst === 1'b1) n_anrst++;
    if (n_cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  // compare a register word
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask
  // compare a pin level
  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t pin %b expected %b", $time, g, e);
    end
  endtask
  // bus accesses through the model
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    pbcs_sm_model_inst.wr(a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    pbcs_sm_model_inst.idle(8);
    pbcs_sm_model_inst.rd(a, v);
    chk16(v, e);
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    {rst_n, an_done, an_spd, an_fd, link, rfault, jab} = 7'h00;
    {sp_st, an_st, iso_st, dup_st} = 4'hc;
    {n_errors, n_compared, n_cyc, n_srst, n_anrst} = '0;
    fork
      pbcs_sm_model_inst.idle(26);
      repeat (8) @(negedge clk);
    join
    rst_n = 1'b1;
    pbcs_sm_model_inst.idle(40);
    rdc(REG_CTRL, 16'h3100);
    rdc(REG_STAT, 16'h7849);
    chk1(an_en, 1'b1);
    chk1(iso, 1'b0);
    // negotiated result overrides manual speed and duplex
    @(negedge clk);
    {an_done, an_spd, an_fd} = 3'b100;
    repeat (4) @(negedge clk);
    chk1(spd, 1'b0);
    chk1(fd, 1'b0);
    // manual mode, reserved bits written with ones
    wr(REG_CTRL, 16'h61ff);
    rdc(REG_CTRL, 16'h6181);
    chk1(loop, 1'b1);
    chk1(spd, 1'b1);
    chk1(fd, 1'b1);
    chk1(col, 1'b1);
    chk1(txdis, 1'b1);
    chk1(an_en, 1'b0);
    // restart pulses once and clears itself
    k = n_anrst;
    wr(REG_CTRL, 16'h1200);
    rdc(REG_CTRL, 16'h1000);
    chk1(n_anrst == k + 1, 1'b1);
    // power down and isolate, registers still reachable
    wr(REG_CTRL, 16'h0c00);
    rdc(REG_CTRL, 16'h0c00);
    chk1(iso, 1'b1);
    chk1(pdown, 1'b1);
    chk1(txdis, 1'b1);
    wr(REG_CTRL, 16'h0000);
    // one-cycle events latch until read, link latches low
    @(negedge clk);
    {rfault, jab, link} = 3'b111;
    @(negedge clk);
    {rfault, jab} = 2'b00;
    rdc(REG_STAT, 16'h787b);
    rdc(REG_STAT, 16'h786d);
    @(negedge clk);
    link = 1'b0;
    @(negedge clk);
    link = 1'b1;
    rdc(REG_STAT, 16'h7869);
    // soft reset reloads strap defaults
    k = n_srst;
    wr(REG_CTRL, 16'h8000);
    rdc(REG_CTRL, 16'h3100);
    chk1(n_srst == k + 1, 1'b1);
    // other strap levels reload on the next soft reset
    @(negedge clk);
    {sp_st, an_st, iso_st, dup_st} = 4'h3;
    wr(REG_CTRL, 16'h8000);
    rdc(REG_CTRL, 16'h0400);
    chk1(iso, 1'b1);
    chk1(an_en, 1'b0);
    chk1(fd, 1'b0);
    chk1(spd, 1'b0);
    rdc(5'h02, 16'h0000);
    test_done();
  end
endmodule
